/* File: inc/ebt_pkg.sv */
// Purpose: Constants for the eight-bit waveform timer
// Assumes: AXI4-Lite, 32-bit data, aligned word registers
// Notes:   Offsets are byte addresses
package ebt_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] EBT_OFF_CTRL   = 8'h00;
   localparam logic [7:0] EBT_OFF_COUNT  = 8'h04;
   localparam logic [7:0] EBT_OFF_CMPA   = 8'h08;
   localparam logic [7:0] EBT_OFF_CMPB   = 8'h0C;
   localparam logic [7:0] EBT_OFF_STATUS = 8'h10;
   localparam logic [7:0] EBT_OFF_FORCE  = 8'h14;
   localparam logic [7:0] EBT_OFF_PORT   = 8'h18;
   // ************************************************************
   // Control fields
   // ************************************************************
   localparam int EBT_CTL_WGM_LSB  = 0;
   localparam int EBT_CTL_CSEL_LSB = 4;
   localparam int EBT_CTL_COMB_LSB = 8;
   localparam int EBT_CTL_COMA_LSB = 10;
   // Status bits; OVF, CFA, CFB write one to clear
   localparam int EBT_ST_OVF  = 0;
   localparam int EBT_ST_CFA  = 1;
   localparam int EBT_ST_CFB  = 2;
   localparam int EBT_ST_OCA  = 3;
   localparam int EBT_ST_OCB  = 4;
   // Force and port bits
   localparam int EBT_FRC_A   = 0;
   localparam int EBT_FRC_B   = 1;
   localparam int EBT_PRT_VA  = 0;
   localparam int EBT_PRT_VB  = 1;
   localparam int EBT_PRT_DA  = 2;
   localparam int EBT_PRT_DB  = 3;
   localparam int EBT_SVC_ACK = 4;
   // ************************************************************
   // Modes and values
   // ************************************************************
   localparam logic [2:0] EBT_WGM_FREE  = 3'h0;
   localparam logic [2:0] EBT_WGM_CLEAR = 3'h2;
   localparam logic [2:0] EBT_WGM_PWMF  = 3'h3;
   localparam logic [2:0] EBT_WGM_PWMA  = 3'h7;
   localparam logic [1:0] EBT_COM_OFF   = 2'h0;
   localparam logic [1:0] EBT_COM_TGL   = 2'h1;
   localparam logic [1:0] EBT_COM_CLR   = 2'h2;
   localparam logic [1:0] EBT_COM_SET   = 2'h3;
   localparam logic [7:0] EBT_MAX       = 8'hFF;
   localparam logic [7:0] EBT_BOTTOM    = 8'h00;
   localparam logic [1:0] EBT_RESP_OK   = 2'h0;
   localparam logic [1:0] EBT_RESP_ERR  = 2'h2;
   // Prescale selects: stop, 1, 8, 64, 256, 1024
   localparam logic [2:0] EBT_CS_STOP = 3'h0;
   localparam logic [2:0] EBT_CS_1    = 3'h1;
   localparam logic [2:0] EBT_CS_8    = 3'h2;
   localparam logic [2:0] EBT_CS_64   = 3'h3;
   localparam logic [2:0] EBT_CS_256  = 3'h4;
   localparam logic [2:0] EBT_CS_1024 = 3'h5;
   localparam logic [9:0] EBT_DIV_8    = 10'h007;
   localparam logic [9:0] EBT_DIV_64   = 10'h03F;
   localparam logic [9:0] EBT_DIV_256  = 10'h0FF;
   localparam logic [9:0] EBT_DIV_1024 = 10'h3FF;
endpackage

/* File: src/ebt_timer.sv */
// Purpose: Eight-bit timer with compare unit, AXI4-Lite slave
// Assumes: Single clock, synchronous active-low reset
// Notes:   Outputs registered; pins split into value and enable
//
// Function
// - Mode zero leaves compare output untouched
// - New output mode governs next match
// - Force strobe applies action in non-PWM
// - Counting set by waveform mode only
// - Free mode counts up, wraps 0xFF->0x00
// - Free mode sets overflow at zero
// - Servicing overflow clears overflow flag
// - Counter writable anytime in free mode
// - Clear mode clears after reaching A
// - Clear mode sets compare flag A
// - Clear mode compare A unbuffered
// - Clear mode toggle; pin needs direction
// - Clear mode overflow on MAX to zero
// - Prescale 1,8,64,256,1024 selectable
// - Fast PWM modes 3 and 7, tops
// - PWM clear on match, set bottom
// - PWM clears next tick after top
// - PWM overflow set at top
// - PWM mode two normal, three inverted
// - PWM toggle only A with bit2
// - PWM period 256 ticks at top 0xFF
// - Output register forceable before enabling pin
// - Reset clears compare output register
// - Counter write blocks next tick matches
// - Nonzero mode overrides port value
//
// Chosen here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ebt_timer
   import ebt_pkg::*;
(
   // Clock, reset, enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // AXI4-Lite write
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Pins
   output logic             pin_a_o,
   output logic             pin_a_oe,
   output logic             pin_b_o,
   output logic             pin_b_oe
);
   typedef struct packed {
      logic        awr;
      logic        wr;
      logic        bv;
      logic [1:0]  br;
      logic        arr;
      logic        rv;
      logic [31:0] rd;
      logic [1:0]  rr;
      logic [7:0]  aw;
      logic [31:0] wd;
      logic [3:0]  ws;
      logic        awh;
      logic        wh;
      logic [2:0]  wgm;
      logic [2:0]  csel;
      logic [1:0]  coma;
      logic [1:0]  comb;
      logic [7:0]  cnt;
      logic [7:0]  cmpa;
      logic [7:0]  cmpb;
      logic [7:0]  cmpa_buf;
      logic [7:0]  cmpb_buf;
      logic        ovf;
      logic        cfa;
      logic        cfb;
      logic        oca;
      logic        ocb;
      logic [3:0]  port;
      logic        blk;
      logic [9:0]  pre;
      logic        pa;
      logic        pae;
      logic        pb;
      logic        pbe;
   } ebt_state_t;

   ebt_state_t s_q;
   ebt_state_t s_d;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic ebt_is_pwm(input logic [2:0] w);
      return (w == EBT_WGM_PWMF) || (w == EBT_WGM_PWMA);
   endfunction

   function automatic logic ebt_act(input logic [1:0] c,
                                    input logic       o);
      unique case (c)
         EBT_COM_OFF: return o;
         EBT_COM_TGL: return ~o;
         EBT_COM_CLR: return 1'b0;
         EBT_COM_SET: return 1'b1;
      endcase
   endfunction

   function automatic logic [7:0] ebt_merge(input logic [7:0] o,
                                            input logic [7:0] n,
                                            input logic       e);
      return e ? n : o;
   endfunction

   logic       tick;
   logic [7:0] top;
   logic [7:0] ca;
   logic [7:0] cb;
   logic       at_top;
   logic       m_a;
   logic       m_b;
   logic       do_w;
   logic       do_r;
   logic [31:0] rdv;
   logic        ovf_set;

   always_comb
   begin
      s_d = s_q;
      // ************************************************************
      // Prescaler
      // ************************************************************
      tick = 1'b0;
      unique case (s_q.csel)
         EBT_CS_1:    tick = 1'b1;
         EBT_CS_8:    tick = (s_q.pre & EBT_DIV_8) == EBT_DIV_8;
         EBT_CS_64:   tick = (s_q.pre & EBT_DIV_64) == EBT_DIV_64;
         EBT_CS_256:  tick = (s_q.pre & EBT_DIV_256) == EBT_DIV_256;
         EBT_CS_1024: tick = s_q.pre == EBT_DIV_1024;
         default:     tick = 1'b0;
      endcase
      s_d.pre = (s_q.csel == EBT_CS_STOP) ? s_q.pre : s_q.pre + 10'h001;
      // ************************************************************
      // Counter and compare
      // ************************************************************
      ca = ebt_is_pwm(s_q.wgm) ? s_q.cmpa_buf : s_q.cmpa;
      cb = ebt_is_pwm(s_q.wgm) ? s_q.cmpb_buf : s_q.cmpb;
      top = (s_q.wgm == EBT_WGM_CLEAR || s_q.wgm == EBT_WGM_PWMA)
            ? ca : EBT_MAX;
      at_top = s_q.cnt == top;
      m_a = tick && !s_q.blk && s_q.cnt == ca;
      m_b = tick && !s_q.blk && s_q.cnt == cb;
      ovf_set = tick && (ebt_is_pwm(s_q.wgm) ? at_top
                                             : s_q.cnt == EBT_MAX);
      if (tick)
      begin
         s_d.blk = 1'b0;
         if (s_q.wgm == EBT_WGM_CLEAR || ebt_is_pwm(s_q.wgm))
            s_d.cnt = at_top ? EBT_BOTTOM : s_q.cnt + 8'h01;
         else
            s_d.cnt = s_q.cnt + 8'h01;
         if (ebt_is_pwm(s_q.wgm))
         begin
            if (at_top)
            begin
               s_d.ovf = 1'b1;
               s_d.cmpa_buf = s_q.cmpa;
               s_d.cmpb_buf = s_q.cmpb;
               // Bottom action
               if (s_q.coma == EBT_COM_CLR) s_d.oca = 1'b1;
               if (s_q.coma == EBT_COM_SET) s_d.oca = 1'b0;
               if (s_q.comb == EBT_COM_CLR) s_d.ocb = 1'b1;
               if (s_q.comb == EBT_COM_SET) s_d.ocb = 1'b0;
            end
            if (m_a && !(at_top && s_q.coma != EBT_COM_TGL))
            begin
               if (s_q.coma == EBT_COM_TGL && s_q.wgm[2])
                  s_d.oca = ~s_q.oca;
               else if (s_q.coma[1])
                  s_d.oca = ebt_act(s_q.coma, s_q.oca);
            end
            if (m_b && !at_top && s_q.comb[1])
               s_d.ocb = ebt_act(s_q.comb, s_q.ocb);
         end
         else
         begin
            if (s_q.cnt == EBT_MAX)
               s_d.ovf = 1'b1;
            if (m_a) s_d.oca = ebt_act(s_q.coma, s_q.oca);
            if (m_b) s_d.ocb = ebt_act(s_q.comb, s_q.ocb);
         end
         if (m_a) s_d.cfa = 1'b1;
         if (m_b) s_d.cfb = 1'b1;
      end
      // ************************************************************
      // AXI4-Lite slave
      // ************************************************************
      if (s_q.awr && s_axi_awvalid)
      begin
         s_d.aw = s_axi_awaddr;
         s_d.awh = 1'b1;
         s_d.awr = 1'b0;
      end
      if (s_q.wr && s_axi_wvalid)
      begin
         s_d.wd = s_axi_wdata;
         s_d.ws = s_axi_wstrb;
         s_d.wh = 1'b1;
         s_d.wr = 1'b0;
      end
      do_w = s_q.awh && s_q.wh && !s_q.bv;
      if (s_q.bv && s_axi_bready)
      begin
         s_d.bv = 1'b0;
         s_d.awr = 1'b1;
         s_d.wr = 1'b1;
      end
      if (do_w)
      begin
         s_d.awh = 1'b0;
         s_d.wh = 1'b0;
         s_d.bv = 1'b1;
         s_d.br = EBT_RESP_OK;
         unique case (s_q.aw)
            EBT_OFF_CTRL:
            begin
               s_d.wgm = s_q.ws[0] ? s_q.wd[EBT_CTL_WGM_LSB +: 3] : s_q.wgm;
               s_d.csel = s_q.ws[0] ? s_q.wd[EBT_CTL_CSEL_LSB +: 3]
                                    : s_q.csel;
               if (s_q.ws[1])
               begin
                  s_d.coma = s_q.wd[EBT_CTL_COMA_LSB +: 2];
                  s_d.comb = s_q.wd[EBT_CTL_COMB_LSB +: 2];
               end
            end
            EBT_OFF_COUNT:
               if (s_q.ws[0])
               begin
                  s_d.cnt = s_q.wd[7:0];
                  s_d.blk = 1'b1;
               end
            EBT_OFF_CMPA: s_d.cmpa = ebt_merge(s_q.cmpa, s_q.wd[7:0],
                                               s_q.ws[0]);
            EBT_OFF_CMPB: s_d.cmpb = ebt_merge(s_q.cmpb, s_q.wd[7:0],
                                               s_q.ws[0]);
            EBT_OFF_STATUS:
               if (s_q.ws[0])
               begin
                  // Set from this cycle's event wins over clear
                  if (s_q.wd[EBT_ST_OVF] && !ovf_set)
                     s_d.ovf = 1'b0;
                  if (s_q.wd[EBT_ST_CFA] && !m_a)
                     s_d.cfa = 1'b0;
                  if (s_q.wd[EBT_ST_CFB] && !m_b)
                     s_d.cfb = 1'b0;
               end
            EBT_OFF_FORCE:
               if (s_q.ws[0] && !ebt_is_pwm(s_q.wgm))
               begin
                  if (s_q.wd[EBT_FRC_A])
                     s_d.oca = ebt_act(s_q.coma, s_q.oca);
                  if (s_q.wd[EBT_FRC_B])
                     s_d.ocb = ebt_act(s_q.comb, s_q.ocb);
               end
            EBT_OFF_PORT:
               if (s_q.ws[0])
               begin
                  s_d.port = s_q.wd[3:0];
                  if (s_q.wd[EBT_SVC_ACK] && !ovf_set)
                     s_d.ovf = 1'b0;
               end
            default: s_d.br = EBT_RESP_ERR;
         endcase
      end
      // ************************************************************
      // Reads
      // ************************************************************
      do_r = s_q.arr && s_axi_arvalid;
      rdv = 32'h0000_0000;
      if (s_q.rv && s_axi_rready)
      begin
         s_d.rv = 1'b0;
         s_d.arr = 1'b1;
      end
      if (do_r)
      begin
         s_d.arr = 1'b0;
         s_d.rv = 1'b1;
         s_d.rr = EBT_RESP_OK;
         unique case (s_axi_araddr)
            EBT_OFF_CTRL:
            begin
               rdv[EBT_CTL_WGM_LSB +: 3] = s_q.wgm;
               rdv[EBT_CTL_CSEL_LSB +: 3] = s_q.csel;
               rdv[EBT_CTL_COMB_LSB +: 2] = s_q.comb;
               rdv[EBT_CTL_COMA_LSB +: 2] = s_q.coma;
            end
            EBT_OFF_COUNT: rdv[7:0] = s_q.cnt;
            EBT_OFF_CMPA:  rdv[7:0] = s_q.cmpa;
            EBT_OFF_CMPB:  rdv[7:0] = s_q.cmpb;
            EBT_OFF_STATUS:
            begin
               rdv[EBT_ST_OVF] = s_q.ovf;
               rdv[EBT_ST_CFA] = s_q.cfa;
               rdv[EBT_ST_CFB] = s_q.cfb;
               rdv[EBT_ST_OCA] = s_q.oca;
               rdv[EBT_ST_OCB] = s_q.ocb;
            end
            EBT_OFF_FORCE: rdv = 32'h0000_0000;
            EBT_OFF_PORT:  rdv[3:0] = s_q.port;
            default:       s_d.rr = EBT_RESP_ERR;
         endcase
         s_d.rd = rdv;
      end
      // Pins: override when output mode nonzero
      s_d.pa = (s_d.coma != EBT_COM_OFF) ? s_d.oca
                                         : s_d.port[EBT_PRT_VA];
      s_d.pae = s_d.port[EBT_PRT_DA];
      s_d.pb = (s_d.comb != EBT_COM_OFF) ? s_d.ocb
                                         : s_d.port[EBT_PRT_VB];
      s_d.pbe = s_d.port[EBT_PRT_DB];
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready = s_q.awr;
   assign s_axi_wready  = s_q.wr;
   assign s_axi_bvalid  = s_q.bv;
   assign s_axi_bresp   = s_q.br;
   assign s_axi_arready = s_q.arr;
   assign s_axi_rvalid  = s_q.rv;
   assign s_axi_rdata   = s_q.rd;
   assign s_axi_rresp   = s_q.rr;
   assign pin_a_o       = s_q.pa;
   assign pin_a_oe      = s_q.pae;
   assign pin_b_o       = s_q.pb;
   assign pin_b_oe      = s_q.pbe;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_q     <= '0;
         s_q.awr <= 1'b1;
         s_q.wr  <= 1'b1;
         s_q.arr <= 1'b1;
      end
      else if (ce)
         s_q <= s_d;
   end

   // ************************************************************
   // Checks
   // ************************************************************
   AST_COM_OFF: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && s_q.coma == EBT_COM_OFF |=> $stable(s_q.oca))
      else $error("compare output moved with mode off");
   AST_OVF_WRAP: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && tick && !do_w && s_q.wgm == EBT_WGM_FREE && s_q.cnt == EBT_MAX
      |=> s_q.ovf && s_q.cnt == EBT_BOTTOM)
      else $error("free mode wrap did not flag overflow");
   AST_CLEAR_TOP: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && tick && !do_w && !s_q.blk && s_q.wgm == EBT_WGM_CLEAR
      && s_q.cnt == s_q.cmpa |=> s_q.cnt == EBT_BOTTOM && s_q.cfa)
      else $error("clear mode did not restart at top");
   AST_BLOCK: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && tick && s_q.blk && !do_w |=> $stable(s_q.cfa) && $stable(s_q.cfb))
      else $error("match seen right after counter write");
   AST_FORCE: assert property (@(posedge aclk)
      disable iff (!aresetn)
      ce && do_w && s_q.aw == EBT_OFF_FORCE && s_q.ws[0] && s_q.wd[EBT_FRC_A]
      && !ebt_is_pwm(s_q.wgm) && s_q.coma == EBT_COM_TGL && !m_a
      |=> s_q.oca != $past(s_q.oca))
      else $error("force strobe did not toggle output");
   AST_PIN_SRC: assert property (@(posedge aclk)
      disable iff (!aresetn)
      pin_a_oe == s_q.port[EBT_PRT_DA]
      && (s_q.coma == EBT_COM_OFF || pin_a_o == s_q.oca))
      else $error("pin A source or direction wrong");
   COV_CLEAR_MATCH: cover property (@(posedge aclk)
      ce && m_a && s_q.wgm == EBT_WGM_CLEAR);
   COV_PWM_TOP: cover property (@(posedge aclk)
      ce && tick && at_top && ebt_is_pwm(s_q.wgm));
   COV_FREE_WRAP: cover property (@(posedge aclk)
      ce && ovf_set && s_q.wgm == EBT_WGM_FREE);
endmodule

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the eight-bit timer
// Assumes: ce low once to freeze, full-word writes, pin B unobserved
// Notes:   Pin timing judged by counting over whole periods
`timescale 1ns/1ps
module tb
   import ebt_pkg::*;
;
   // ****
   // Signals
   // ****
   logic        aclk;
   logic        aresetn = 1'b0;
   logic        ce      = 1'b1;
   logic [3:0]  wstrb   = 4'hF;
   logic [7:0]  awaddr  = 8'h00;
   logic [7:0]  araddr  = 8'h00;
   logic [31:0] wdata   = 32'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, pa, pa_oe;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, rv;
   int          bad_count, cmp_count, hi, ed, e;
   logic [7:0]  ta [4] = '{EBT_OFF_CMPA, EBT_OFF_CMPB, EBT_OFF_COUNT,
                           EBT_OFF_CTRL};
   logic [31:0] td [4] = '{32'h55, 32'hAA, 32'h3C, 32'h0A02};
   logic [31:0] te [4] = '{32'h55, 32'hAA, 32'h3C, 32'h0A02};

   ebt_timer u_ebt_timer (
      .aclk(aclk), .aresetn(aresetn), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .pin_a_o(pa), .pin_a_oe(pa_oe),
      .pin_b_o(), .pin_b_oe()
   );

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // ****
   // Tasks
   // ****
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] x,
                      input string m);
      cmp_count++;
      if (g !== x)
      begin
         bad_count++;
         $display("unexpected at %0t: %s got %h", $time, m, g);
      end
   endtask

   task automatic chk_rsp(input logic [1:0] g, input logic [1:0] x);
      chk({30'h0, g}, {30'h0, x}, "resp");
   endtask

   task automatic hang();
      bad_count++;
      $display("unexpected at %0t: no handshake", $time);
      give_verdict();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      repeat (50)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
         begin
            rsp = bresp;
            bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      repeat (50)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
         begin
            rv = rdata;
            rsp = rresp;
            rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask

   // High cycles and edges of pin A over n cycles
   task automatic watch(input int n);
      logic l;
      hi = 0;
      ed = 0;
      l = pa;
      repeat (n)
      begin
         @(posedge aclk);
         if (pa === 1'b1)
            hi++;
         if (pa !== l)
            ed++;
         l = pa;
      end
   endtask

   function automatic logic [31:0] ctl(logic [2:0] w, logic [2:0] c,
                                       logic [1:0] a);
      return {20'h0_0000, a, 2'h0, 1'h0, c, 1'h0, w};
   endfunction

   // ****
   // Sequence
   // ****
   initial
   begin
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      rd(EBT_OFF_STATUS);
      chk(rv, 32'h0, "status");
      chk(32'(pa_oe), 32'h0, "oe");
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         wr(ta[i], td[i]);
         rd(ta[i]);
         chk(rv, te[i], "table");
      end
      wr(8'h1C, 32'h0);
      chk_rsp(rsp, EBT_RESP_ERR);
      rd(8'h1C);
      chk_rsp(rsp, EBT_RESP_ERR);
      $display("test table done");
      wr(EBT_OFF_CTRL, ctl(EBT_WGM_FREE, EBT_CS_STOP, EBT_COM_OFF));
      wr(EBT_OFF_FORCE, 32'h1);
      rd(EBT_OFF_STATUS);
      chk(32'(rv[EBT_ST_OCA]), 32'h0, "no action");
      wr(EBT_OFF_CTRL, ctl(EBT_WGM_FREE, EBT_CS_STOP, EBT_COM_TGL));
      wr(EBT_OFF_FORCE, 32'h1);
      rd(EBT_OFF_STATUS);
      chk(32'(rv[EBT_ST_OCA]), 32'h1, "force");
      chk(32'(rv[EBT_ST_CFA]), 32'h0, "force flag");
      chk(32'(pa_oe), 32'h0, "oe off");
      wr(EBT_OFF_PORT, 32'h4);
      rd(EBT_OFF_STATUS);
      chk({30'h0, pa_oe, pa}, 32'h3, "pin");
      $display("test force done");
      for (int i = 0; i < 3; i++)
      begin
         wr(EBT_OFF_CTRL, ctl(EBT_WGM_CLEAR, EBT_CS_STOP, EBT_COM_TGL));
         wr(EBT_OFF_COUNT, 32'h0);
         wr(EBT_OFF_CMPA, 32'h4);
         wr(EBT_OFF_CTRL, ctl(EBT_WGM_CLEAR, 3'(i + 1), EBT_COM_TGL));
         watch(10 << (3 * i));
         watch(100 << (3 * i));
         chk(32'(ed), 32'd20, "toggle rate");
         rd(EBT_OFF_COUNT);
         chk(32'(rv <= 32'h4), 32'h1, "top");
         rd(EBT_OFF_STATUS);
         chk(32'(rv[EBT_ST_CFA]), 32'h1, "match flag");
      end
      $display("test clear mode done");
      wr(EBT_OFF_CTRL, ctl(EBT_WGM_FREE, EBT_CS_STOP, EBT_COM_OFF));
      wr(EBT_OFF_STATUS, 32'h1);
      wr(EBT_OFF_COUNT, 32'hF0);
      wr(EBT_OFF_CTRL, ctl(EBT_WGM_FREE, EBT_CS_1, EBT_COM_OFF));
      rv = 32'h0;
      for (int i = 0; i < 30 && !rv[EBT_ST_OVF]; i++)
         rd(EBT_OFF_STATUS);
      chk(32'(rv[EBT_ST_OVF]), 32'h1, "overflow");
      rd(EBT_OFF_COUNT);
      chk(32'(rv < 32'h20), 32'h1, "wrapped");
      wr(EBT_OFF_PORT, 32'h14);
      rd(EBT_OFF_STATUS);
      chk(32'(rv[EBT_ST_OVF]), 32'h0, "serviced");
      rd(EBT_OFF_COUNT);
      e = int'(rv[7:0]);
      ce <= 1'b0;
      repeat (50) @(posedge aclk);
      ce <= 1'b1;
      rd(EBT_OFF_COUNT);
      chk(32'(8'(rv[7:0] - e[7:0]) < 8'd20), 32'h1, "frozen");
      $display("test overflow done");
      wr(EBT_OFF_CMPA, 32'h40);
      for (int i = 0; i < 2; i++)
      begin
         wr(EBT_OFF_CTRL, ctl(EBT_WGM_PWMF, EBT_CS_1, 2'(2 + i)));
         e = (i == 0) ? 64 : 192;
         watch(300);
         watch(256);
         chk(32'(hi >= e - 1 && hi <= e + 1), 32'h1, "duty");
         chk(32'(ed), 32'h2, "period");
      end
      wr(EBT_OFF_CMPA, 32'h1F);
      wr(EBT_OFF_CTRL, ctl(EBT_WGM_PWMA, EBT_CS_1, EBT_COM_TGL));
      watch(300);
      watch(256);
      chk(32'(ed), 32'h8, "top A");
      $display("test pwm done");
      give_verdict();
   end
endmodule
